// >>> testbench/clr_host.sv
`timescale 1ns/1ps
`default_nettype none
module clr_host (
  // Clock and the resolved data wire.
  input wire logic clk,
  input wire logic sda,
  // Bus clock and data release.
  output logic scl,
  output logic sda_rel
);
  logic r;
  // Both lines start released, as the bus is between frames.
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Sets data mid-low, then the clock; a low phase of eight clocks covers slave setup.
  task automatic ph(input logic s, input logic d);
    repeat (4) @(posedge clk);
    #2 sda_rel = d;
    repeat (4) @(posedge clk);
    #2 scl = s;
  endtask
  // One bit out and the wire's level read back at the end of the high phase.
  task automatic bt(input logic b, output logic o);
    ph(1'b1, b);
    repeat (6) @(posedge clk);
    #2 o = sda;
    scl = 1'b0;
  endtask
  task automatic tx(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) bt(b[i], r);
    bt(1'b1, nak);
  endtask
  task automatic rx(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
    bt(last, r);
  endtask
  // Write word: start, address, command, low byte, high byte, stop.
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    output logic [3:0] nk);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b0);
    tx({a, 1'b0}, nk[3]);
    tx(c, nk[2]);
    tx(d[7:0], nk[1]);
    tx(d[15:8], nk[0]);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // Read word; the low byte is acknowledged and the high byte ends the read.
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b0);
    tx({clr_pkg::SLAVE_ADDR, 1'b0}, r);
    tx(c, r);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b0);
    tx({clr_pkg::SLAVE_ADDR, 1'b1}, r);
    rx(1'b0, d[7:0]);
    rx(1'b1, d[15:8]);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
endmodule
`default_nettype wire

// >>> testbench/clr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clr_top_bench;
  typedef struct packed {logic [7:0] c; logic [15:0] d; logic [15:0] r; logic [15:0] m;} clr_row_t;
  // Command and word written, then the word read back and the millivolt output.
  // Reserved bits 15..14 stay zero in every row, as the host must keep them.
  clr_row_t rows [5] = '{'{8'h3D, 16'h3FC0, 16'h3FC0, 16'h4C40},
                         '{8'h3B, 16'h2000, 16'h2000, 16'h3180},
                         '{8'h3D, 16'h003F, 16'h0000, 16'h0C80},
                         '{8'h3B, 16'h3FC0, 16'h3FC0, 16'h5140},
                         '{8'h3D, 16'h1000, 16'h1000, 16'h1C80}};
  logic clk, rst_n, ce, ld, scl, rel, oe_n, sda_o;
  logic [6:0] code;
  logic [7:0] bus, nol;
  logic [15:0] iin, flr, otg, rv;
  logic dynamic_power_management;
  logic [3:0] nk;
  int err_total, num_checks;
  // The data wire has a pull-up, so it is high unless a party pulls it low.
  wire logic sda = rel & (oe_n | sda_o);
  clr_top u_dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_N(oe_n), .DPM_LIMIT_CODE(code), .DPM_LIMIT_LOAD(ld), .INPUT_BUS_CODE(bus),
    .NOLOAD_BUS_CODE(nol), .IIN_LIMIT_MA(iin), .FLOOR_MV(flr), .OTG_MV(otg), .DPM_ACTIVE(dynamic_power_management));
  clr_host u_host (.clk(clk), .sda(sda), .scl(scl), .sda_rel(rel));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Some twenty frames of under two thousand clocks each fit well inside this span.
  initial begin
    #2ms;
    err_total++;
    close_out();
  end
  // Reset, the table of writes, then the awkward cases.
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    ld = 1'b0;
    code = 7'h7F;
    bus = 8'hC8;
    nol = 8'h64;
    repeat (5) @(posedge clk);
    #2 chk("iin", 16'h0032, iin);
    chk("flr", 16'h0C80, flr);
    chk("otg", 16'h1180, otg);
    chk("dpm", 16'h0000, dynamic_power_management);
    chk("sdao", 16'h0000, sda_o);
    chk("oen", 16'h0001, oe_n);
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #2 chk("dflt", 16'h2080, flr);
    u_host.rd(8'h22, rv);
    chk("rep", 16'h0000, rv);
    foreach (rows[i]) begin
      u_host.wr(clr_pkg::SLAVE_ADDR, rows[i].c, rows[i].d, nk);
      chk("nak", 16'h0000, nk);
      u_host.rd(rows[i].c, rv);
      chk("read", rows[i].r, rv);
      chk("mv", rows[i].m, rows[i].c == 8'h3D ? flr : otg);
      chk("sdao", 16'h0000, sda_o);
    end
    ld = 1'b1;
    @(posedge clk);
    #2 ld = 1'b0;
    @(posedge clk);
    #2 chk("iin", 16'd6400, iin);
    // A frozen block must neither load the report nor move the current output.
    ce = 1'b0;
    ld = 1'b1;
    code = 7'h01;
    repeat (2) @(posedge clk);
    #2 ce = 1'b1;
    ld = 1'b0;
    repeat (2) @(posedge clk);
    #2 chk("frz", 16'd6400, iin);
    u_host.wr(clr_pkg::SLAVE_ADDR, 8'h22, 16'h0100, nk);
    chk("nak", 16'h0000, nk);
    u_host.rd(8'h22, rv);
    chk("rep", 16'h7F00, rv);
    for (int i = 0; i < 2; i++) begin
      u_host.wr(clr_pkg::SLAVE_ADDR, 8'h3D, 16'h8000 >> i, nk);
      chk("flr", 16'd7296, flr);
    end
    u_host.wr(7'h2B, 8'h3D, 16'h0040, nk);
    chk("nak", 16'h000F, nk);
    chk("flr", 16'd7296, flr);
    bus = 8'h3F;
    repeat (2) @(posedge clk);
    #2 chk("dpm", 16'h0001, dynamic_power_management);
    bus = 8'h40;
    repeat (2) @(posedge clk);
    #2 chk("dpm", 16'h0000, dynamic_power_management);
    bus = 8'hC8;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #2 rst_n = 1'b1;
    chk("otg", 16'h1180, otg);
    repeat (4) @(posedge clk);
    #2 chk("dflt", 16'h2080, flr);
    u_host.rd(8'h3B, rv);
    chk("otgrd", 16'h0000, rv);
    close_out();
  end
endmodule
`default_nettype wire

// >>> testbench/clr_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module clr_top_sva (
  // Clock, reset, enable and bus clock.
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic SCL_I,
  // Regulation inputs and settings.
  input wire logic [6:0] DPM_LIMIT_CODE,
  input wire logic DPM_LIMIT_LOAD,
  input wire logic [7:0] INPUT_BUS_CODE,
  input wire logic [7:0] NOLOAD_BUS_CODE,
  input wire logic [15:0] IIN_LIMIT_MA,
  input wire logic [15:0] FLOOR_MV,
  input wire logic [15:0] OTG_MV,
  input wire logic DPM_ACTIVE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Offsets removed; the floor default clamps at zero for low buses.
  wire logic [15:0] flr_ofs = FLOOR_MV - 16'h0C80;
  wire logic [15:0] otg_ofs = OTG_MV - 16'h1180;
  wire logic [7:0] dflt = (NOLOAD_BUS_CODE > 8'h13) ? NOLOAD_BUS_CODE - 8'h14 : 8'h00;
  property p_iin;
    CE && DPM_LIMIT_LOAD ##1 CE |=> IIN_LIMIT_MA == 16'h0032 + 16'h0032 * $past(DPM_LIMIT_CODE, 2);
  endproperty
  property p_hold;
    !DPM_LIMIT_LOAD [*2] |=> $stable(IIN_LIMIT_MA);
  endproperty
  property p_flr;
    flr_ofs[5:0] == 6'h00 && FLOOR_MV >= 16'h0C80 && FLOOR_MV <= 16'h4C40;
  endproperty
  property p_otg;
    otg_ofs[5:0] == 6'h00 && OTG_MV >= 16'h1180 && OTG_MV <= 16'h5140;
  endproperty
  property p_dpm;
    $past(CE) |-> DPM_ACTIVE == ($past(INPUT_BUS_CODE) < flr_ofs[13:6]);
  endproperty
  property p_dflt;
    $rose(RST_N) && CE ##1 CE |=> FLOOR_MV == 16'h0C80 + {dflt, 6'h00};
  endproperty
  // Host writes land while the bus clock is low; the reset default is excluded.
  property p_fcause;
    $changed(FLOOR_MV) && $past(RST_N, 3) |-> !SCL_I;
  endproperty
  property p_ocause;
    $changed(OTG_MV) |-> !SCL_I;
  endproperty
  a_iin: assert property (p_iin) else $error("current output wrong");
  a_hold: assert property (p_hold) else $error("report moved");
  a_flr: assert property (p_flr) else $error("floor scale wrong");
  a_otg: assert property (p_otg) else $error("otg scale wrong");
  a_dpm: assert property (p_dpm) else $error("dpm flag wrong");
  a_dflt: assert property (p_dflt) else $error("floor default wrong");
  a_fcause: assert property (p_fcause) else $error("floor moved");
  a_ocause: assert property (p_ocause) else $error("otg moved");
  c_load: cover property (DPM_LIMIT_LOAD);
  c_dpm: cover property ($rose(DPM_ACTIVE));
  c_otg: cover property ($changed(OTG_MV));
endmodule
bind clr_top clr_top_sva u_sva (.CLK(CLK), .RST_N(RST_N), .CE(CE), .SCL_I(SCL_I),
  .DPM_LIMIT_CODE(DPM_LIMIT_CODE), .DPM_LIMIT_LOAD(DPM_LIMIT_LOAD),
  .INPUT_BUS_CODE(INPUT_BUS_CODE), .NOLOAD_BUS_CODE(NOLOAD_BUS_CODE),
  .IIN_LIMIT_MA(IIN_LIMIT_MA), .FLOOR_MV(FLOOR_MV), .OTG_MV(OTG_MV), .DPM_ACTIVE(DPM_ACTIVE));
`default_nettype wire

// >>> verilog/clr_pkg.sv
package clr_pkg;
  // Command codes of the three registers in this slice.
  localparam logic [7:0] CMD_IIN_EFFECTIVE = 8'h22;
  localparam logic [7:0] CMD_OTG_VOLTAGE = 8'h3B;
  localparam logic [7:0] CMD_INPUT_FLOOR = 8'h3D;

  // Bus slave address; the value is arbitrary.
  localparam logic [6:0] SLAVE_ADDR = 7'h2A;

  // Field positions.
  localparam int IIN_MSB = 14;
  localparam int IIN_LSB = 8;
  localparam int VOLT_MSB = 13;
  localparam int VOLT_LSB = 6;
  localparam int RSVD_HI_MSB = 15;
  localparam int RSVD_HI_LSB = 14;

  // Reset values.
  localparam logic [6:0] IIN_RESET = 7'h00;
  localparam logic [7:0] OTG_RESET = 8'h00;
  localparam logic [7:0] FLOOR_RESET = 8'h00;

  // Scaling: fixed offsets and step sizes.
  localparam logic [15:0] IIN_OFFSET_MA = 16'h0032;
  localparam logic [15:0] IIN_STEP_MA = 16'h0032;
  localparam logic [15:0] FLOOR_OFFSET_MV = 16'h0C80;
  localparam logic [15:0] OTG_OFFSET_MV = 16'h1180;
  localparam int VOLT_STEP_MV = 64;
  localparam int FLOOR_DROP_MV = 1280;
  localparam logic [7:0] FLOOR_DROP_CODE = 8'(FLOOR_DROP_MV / VOLT_STEP_MV);

  // Bit counter and byte index values of the serial engine.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_BIT_SENT = 4'h1;
  localparam logic [2:0] IDX_ADDR = 3'h0;
  localparam logic [2:0] IDX_CMD = 3'h1;
  localparam logic [2:0] IDX_LO = 3'h2;
  localparam logic [2:0] IDX_HI = 3'h3;
  localparam logic [2:0] IDX_OVER = 3'h4;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} clr_state_t;
endpackage

// >>> verilog/clr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module clr_sync #(
  parameter int W = 2
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two flops per bit; the first is read by the second only. Bus lines idle high.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end else if (ce) begin
          meta_q[g] <= async_in[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> verilog/clr_top.sv
// Contract
// - Effective current field bits 14..8, 50mA LSB.
// - Effective current at 22h, read-only, reset zero.
// - Floor field bits 13..6, 64mV LSB.
// - Floor has fixed 3.2 V offset.
// - Bus below floor enters dynamic power management.
// - Floor defaults 1.28 V below no-load bus.
// - Reverse voltage has fixed 4.48 V offset.
// - Reverse voltage resets zero, field bits 13..6.
// - Report shows limit actually used by regulation.
// - Effective current has 50 mA offset.
// - Reverse voltage field weights 8192 to 64 mV.
`timescale 1ns/1ps
`default_nettype none
module clr_top (
  // Clock, reset and freeze.
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Serial bus pins; data is open drain.
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  // Regulation side, same clock.
  input wire logic [6:0] DPM_LIMIT_CODE,
  input wire logic DPM_LIMIT_LOAD,
  input wire logic [7:0] INPUT_BUS_CODE,
  input wire logic [7:0] NOLOAD_BUS_CODE,
  // Effective settings towards the analog loops.
  output logic [15:0] IIN_LIMIT_MA,
  output logic [15:0] FLOOR_MV,
  output logic [15:0] OTG_MV,
  output logic DPM_ACTIVE
);
  logic [1:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  clr_pkg::clr_state_t st_q;
  logic [3:0] bitcnt_q;
  logic [2:0] idx_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic drive_q;
  logic rw_q;
  logic mack_q;
  logic hi_sent_q;
  logic [7:0] cmd_q;
  logic [7:0] lo_q;
  logic [15:0] rd_word_q;
  logic [6:0] iin_q;
  logic [7:0] floor_q;
  logic [7:0] otg_q;
  logic floor_init_q;
  logic sda_o_q;
  logic sda_oe_n_q;
  logic [15:0] iin_ma_q;
  logic [15:0] floor_mv_q;
  logic [15:0] otg_mv_q;
  logic dpm_q;

  // Read word for a command; unmapped commands read as zero.
  function automatic logic [15:0] read_word(input logic [7:0] cmd, input logic [6:0] iin,
                                             input logic [7:0] flr, input logic [7:0] otg);
    logic [15:0] w;
    w = 16'h0000;
    if (cmd == clr_pkg::CMD_IIN_EFFECTIVE) begin
      w[clr_pkg::IIN_MSB:clr_pkg::IIN_LSB] = iin;
    end else if (cmd == clr_pkg::CMD_INPUT_FLOOR) begin
      w[clr_pkg::VOLT_MSB:clr_pkg::VOLT_LSB] = flr;
    end else if (cmd == clr_pkg::CMD_OTG_VOLTAGE) begin
      w[clr_pkg::VOLT_MSB:clr_pkg::VOLT_LSB] = otg;
    end
    return w;
  endfunction

  // Pins come from another domain, so they pass two flops first.
  clr_sync #(.W(2)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .async_in({SCL_I, SDA_I}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Line events, seen one flop after synchronisation.
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_w = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire byte_end_w = (st_q == clr_pkg::ST_RX) & scl_fall & (bitcnt_q == clr_pkg::BITS_PER_BYTE);
  wire addr_hit_w = (sh_q[7:1] == clr_pkg::SLAVE_ADDR);
  wire ack_w = (idx_q == clr_pkg::IDX_ADDR) ? addr_hit_w :
               ((idx_q != clr_pkg::IDX_OVER) & ~rw_q);
  wire commit_w = byte_end_w & ack_w & (idx_q == clr_pkg::IDX_HI);
  wire [15:0] wr_word_w = {sh_q, lo_q};
  wire wr_ok_w = (wr_word_w[clr_pkg::RSVD_HI_MSB:clr_pkg::RSVD_HI_LSB] == 2'h0);
  wire [7:0] wr_field_w = wr_word_w[clr_pkg::VOLT_MSB:clr_pkg::VOLT_LSB];
  wire [7:0] floor_dflt_w = (NOLOAD_BUS_CODE >= clr_pkg::FLOOR_DROP_CODE) ?
                            (NOLOAD_BUS_CODE - clr_pkg::FLOOR_DROP_CODE) : 8'h00;

  // Previous line levels for edge and start/stop detection.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (CE) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Serial engine. Data changes only on a clock fall so the master never sees
  // a false start or stop; a NACK drops the transfer back to idle.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= clr_pkg::ST_IDLE;
      bitcnt_q <= 4'h0;
      idx_q <= clr_pkg::IDX_ADDR;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      drive_q <= 1'b0;
      mack_q <= 1'b0;
      hi_sent_q <= 1'b0;
    end else if (CE) begin
      if (start_w) begin
        st_q <= clr_pkg::ST_RX;
        bitcnt_q <= 4'h0;
        idx_q <= clr_pkg::IDX_ADDR;
        drive_q <= 1'b0;
      end else if (stop_w) begin
        st_q <= clr_pkg::ST_IDLE;
        drive_q <= 1'b0;
      end else begin
        case (st_q)
          clr_pkg::ST_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (byte_end_w) begin
              bitcnt_q <= 4'h0;
              if (idx_q != clr_pkg::IDX_OVER) begin
                idx_q <= idx_q + 3'h1;
              end
              drive_q <= ack_w;
              st_q <= ack_w ? clr_pkg::ST_ACK : clr_pkg::ST_IDLE;
            end
          end
          clr_pkg::ST_ACK: begin
            if (scl_fall) begin
              if (rw_q) begin
                drive_q <= ~rd_word_q[7];
                tx_q <= {rd_word_q[6:0], 1'b0};
                bitcnt_q <= clr_pkg::FIRST_BIT_SENT;
                hi_sent_q <= 1'b0;
                st_q <= clr_pkg::ST_TX;
              end else begin
                drive_q <= 1'b0;
                st_q <= clr_pkg::ST_RX;
              end
            end
          end
          clr_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bitcnt_q == clr_pkg::BITS_PER_BYTE) begin
                drive_q <= 1'b0;
                st_q <= clr_pkg::ST_TXACK;
              end else begin
                drive_q <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                bitcnt_q <= bitcnt_q + 4'h1;
              end
            end
          end
          clr_pkg::ST_TXACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
            end else if (scl_fall) begin
              if (mack_q && !hi_sent_q) begin
                drive_q <= ~rd_word_q[15];
                tx_q <= {rd_word_q[14:8], 1'b0};
                bitcnt_q <= clr_pkg::FIRST_BIT_SENT;
                hi_sent_q <= 1'b1;
                st_q <= clr_pkg::ST_TX;
              end else begin
                st_q <= clr_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Transaction bytes. The read word is captured at the address byte so that
  // both halves come from one snapshot even if regulation updates mid-read.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rw_q <= 1'b0;
      cmd_q <= 8'h00;
      lo_q <= 8'h00;
      rd_word_q <= 16'h0000;
    end else if (CE && byte_end_w && ack_w) begin
      if (idx_q == clr_pkg::IDX_ADDR) begin
        rw_q <= sh_q[0];
        rd_word_q <= read_word(cmd_q, iin_q, floor_q, otg_q);
      end else if (idx_q == clr_pkg::IDX_CMD) begin
        cmd_q <= sh_q;
      end else if (idx_q == clr_pkg::IDX_LO) begin
        lo_q <= sh_q;
      end
    end
  end

  // Register bank. The floor cannot take a port value under reset, so it is
  // loaded from the no-load bus code on the first enabled cycle after release.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      iin_q <= clr_pkg::IIN_RESET;
      floor_q <= clr_pkg::FLOOR_RESET;
      otg_q <= clr_pkg::OTG_RESET;
      floor_init_q <= 1'b1;
    end else if (CE) begin
      if (DPM_LIMIT_LOAD) begin
        iin_q <= DPM_LIMIT_CODE;
      end
      if (floor_init_q) begin
        floor_q <= floor_dflt_w;
        floor_init_q <= 1'b0;
      end else if (commit_w && wr_ok_w && cmd_q == clr_pkg::CMD_INPUT_FLOOR) begin
        floor_q <= wr_field_w;
      end
      if (commit_w && wr_ok_w && cmd_q == clr_pkg::CMD_OTG_VOLTAGE) begin
        otg_q <= wr_field_w;
      end
    end
  end

  // Scaled settings and the low-input comparison, all registered outputs.
  // The data enable costs one extra clock of delay, which the long low phase absorbs.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sda_o_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      iin_ma_q <= clr_pkg::IIN_OFFSET_MA;
      floor_mv_q <= clr_pkg::FLOOR_OFFSET_MV;
      otg_mv_q <= clr_pkg::OTG_OFFSET_MV;
      dpm_q <= 1'b0;
    end else if (CE) begin
      sda_o_q <= 1'b0;
      sda_oe_n_q <= ~drive_q;
      iin_ma_q <= clr_pkg::IIN_OFFSET_MA + 16'({9'h000, iin_q} * clr_pkg::IIN_STEP_MA);
      floor_mv_q <= clr_pkg::FLOOR_OFFSET_MV + {2'h0, floor_q, 6'h00};
      otg_mv_q <= clr_pkg::OTG_OFFSET_MV + {2'h0, otg_q, 6'h00};
      dpm_q <= (INPUT_BUS_CODE < floor_q) & ~floor_init_q;
    end
  end

  assign SDA_O = sda_o_q;
  assign SDA_OE_N = sda_oe_n_q;
  assign IIN_LIMIT_MA = iin_ma_q;
  assign FLOOR_MV = floor_mv_q;
  assign OTG_MV = otg_mv_q;
  assign DPM_ACTIVE = dpm_q;
endmodule
`default_nettype wire
